// File: dlcr_pkg.sv
// Constants for the link configuration register group.
// Assumes a byte-wide register port driven by the serial control bus slave.
package dlcr_pkg;
	localparam logic [7:0] ADDR_CFG_ONE  = 8'h03;
	localparam logic [7:0] ADDR_WDOG     = 8'h04;
	localparam logic [7:0] ADDR_BUS_ONE  = 8'h05;
	localparam logic [7:0] RST_CFG_ONE   = 8'hf0;
	localparam logic [7:0] RST_WDOG      = 8'hfe;
	localparam logic [7:0] RST_BUS_ONE   = 8'h2e;
	// Writable bits of the first config register; others hold reset value
	localparam logic [7:0] MASK_CFG_ONE  = 8'h5d;
	localparam int BIT_CRC_EN     = 6;
	localparam int BIT_FILT_EN    = 4;
	localparam int BIT_PASS_THRU  = 3;
	localparam int BIT_AUTO_ACK   = 2;
	localparam int BIT_EDGE_SEL   = 0;
	localparam int BIT_WDOG_DIS   = 0;
	localparam int BIT_PASS_ALL   = 7;
	localparam int CLK_PERIOD_NS  = 10;
	localparam int WDOG_UNIT_NS   = 2000000;
	localparam int WDOG_UNIT_CYC  = WDOG_UNIT_NS / CLK_PERIOD_NS;
	localparam int HOLD_UNIT_NS   = 50;
	// Longest time for the hold unit rounds down
	localparam int HOLD_UNIT_CYC  = HOLD_UNIT_NS / CLK_PERIOD_NS;
	localparam int GLITCH_UNIT_NS = 5;
	// Filter depth unit is half a cycle; round up to whole cycles
	localparam int FILT_MIN_PULSE = 2;
endpackage : dlcr_pkg

// File: dlcr_filter.sv
// Pulse filter: a change passes only after holding for DEPTH+1 samples.
// Assumes input synchronous to clk; depth may change at any time.
`timescale 1ns/1ns
`default_nettype none
module dlcr_filter #(
	parameter int CW = 8
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          reset,
	// Control
	input  wire logic          enable,
	input  wire logic [CW-1:0] depth,
	// Data
	input  wire logic          din,
	output logic               dout
);
	logic [CW-1:0] cnt_q;
	logic          out_q;
	wire           differs = din != out_q;
	wire           settled = cnt_q >= depth;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else if (!enable || (differs && settled)) begin
			cnt_q <= '0;
			out_q <= din;
		end else if (differs) begin
			cnt_q <= cnt_q + 1'b1;
		end else begin
			cnt_q <= '0;
		end
	end

	assign dout = out_q;
endmodule : dlcr_filter
`default_nettype wire

// File: dlcr_regs.sv
// Link configuration registers with sync filter, serial bus conditioning
// and control channel watchdog.
// Assumes a byte register port from the serial control bus slave, and
// pixel-rate inputs synchronous to clk.
//
// How it works
// - CRC on back channel follows bit six
// - Sync filter rejects pulses under two cycles
// - Bit three enables serial pass-through
// - Bit two picks auto or self acknowledge
// - Bit zero picks output strobe edge
// - Watchdog ends overlong control channel transactions
// - Timeout field counts two millisecond units
// - Watchdog disable bit stops the timer
// - Pass-all bit forwards every serial transaction
// - SDA hold equals field times 50 ns
// - Glitches up to field times 5 ns rejected
`timescale 1ns/1ns
`default_nettype none
module dlcr_regs #(
	parameter int WDOG_UNIT = dlcr_pkg::WDOG_UNIT_CYC
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	// Video sync inputs and filtered outputs
	input  wire logic       video_data_enable,
	input  wire logic       horizontal_sync,
	input  wire logic       vertical_sync,
	output logic            video_data_enable_f,
	output logic            horizontal_sync_f,
	output logic            vertical_sync_f,
	// Serial bus inputs and conditioned outputs
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_clean,
	output logic            sda_clean,
	// Control channel transaction
	input  wire logic       ctl_chan_busy,
	output logic            ctl_chan_abort,
	// Mode outputs
	output logic            back_crc_enable,
	output logic            pass_through_enable,
	output logic            auto_ack_enable,
	output logic            pass_all_enable,
	output logic            output_strobe_edge_select
);
	logic [7:0]  cfg_q;
	logic [7:0]  wdog_q;
	logic [7:0]  bus_q;
	logic [31:0] unit_q;
	logic [6:0]  units_q;
	logic        abort_q;
	logic [5:0]  hold_cnt_q;
	logic        sda_hold_q;
	logic        scl_prev_q;

	wire wr_cfg  = reg_wr && reg_addr == dlcr_pkg::ADDR_CFG_ONE;
	wire wr_wdog = reg_wr && reg_addr == dlcr_pkg::ADDR_WDOG;
	wire wr_bus  = reg_wr && reg_addr == dlcr_pkg::ADDR_BUS_ONE;

	// Register writes; reserved bits keep their reset value
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_q  <= dlcr_pkg::RST_CFG_ONE;
			wdog_q <= dlcr_pkg::RST_WDOG;
			bus_q  <= dlcr_pkg::RST_BUS_ONE;
		end else begin
			if (wr_cfg)
				cfg_q <= (reg_wdata & dlcr_pkg::MASK_CFG_ONE) |
					(dlcr_pkg::RST_CFG_ONE & ~dlcr_pkg::MASK_CFG_ONE);
			if (wr_wdog)
				wdog_q <= reg_wdata;
			if (wr_bus)
				bus_q <= reg_wdata;
		end
	end

	assign reg_rdata = (reg_addr == dlcr_pkg::ADDR_CFG_ONE) ? cfg_q :
		(reg_addr == dlcr_pkg::ADDR_WDOG) ? wdog_q :
		(reg_addr == dlcr_pkg::ADDR_BUS_ONE) ? bus_q : 8'h00;

	assign back_crc_enable     = cfg_q[dlcr_pkg::BIT_CRC_EN];
	assign pass_through_enable = cfg_q[dlcr_pkg::BIT_PASS_THRU];
	assign auto_ack_enable     = cfg_q[dlcr_pkg::BIT_AUTO_ACK];
	assign pass_all_enable     = bus_q[dlcr_pkg::BIT_PASS_ALL];
	assign output_strobe_edge_select = cfg_q[dlcr_pkg::BIT_EDGE_SEL];

	// Sync filter: change must hold two cycles before it passes
	wire       filt_en = cfg_q[dlcr_pkg::BIT_FILT_EN];
	localparam logic [1:0] SYNC_DEPTH = 2'(dlcr_pkg::FILT_MIN_PULSE - 1);

	dlcr_filter #(.CW(2)) u_den (
		.clk(clk), .reset(reset), .enable(filt_en), .depth(SYNC_DEPTH),
		.din(video_data_enable), .dout(video_data_enable_f));
	dlcr_filter #(.CW(2)) u_hsync (
		.clk(clk), .reset(reset), .enable(filt_en), .depth(SYNC_DEPTH),
		.din(horizontal_sync), .dout(horizontal_sync_f));
	dlcr_filter #(.CW(2)) u_vsync (
		.clk(clk), .reset(reset), .enable(filt_en), .depth(SYNC_DEPTH),
		.din(vertical_sync), .dout(vertical_sync_f));

	// Glitch filter on serial lines; depth in 5 ns units is half cycles,
	// so the cycle count is the field halved, rounded up
	wire [3:0] glitch_depth = bus_q[3:0];
	wire [3:0] glitch_cyc   = 4'((glitch_depth + 5'd1) >> 1);
	wire       glitch_en    = glitch_depth != 4'h0;
	logic      sda_filt;

	dlcr_filter #(.CW(4)) u_scl (
		.clk(clk), .reset(reset), .enable(glitch_en), .depth(glitch_cyc),
		.din(scl_in), .dout(scl_clean));
	dlcr_filter #(.CW(4)) u_sda (
		.clk(clk), .reset(reset), .enable(glitch_en), .depth(glitch_cyc),
		.din(sda_in), .dout(sda_filt));

	// SDA hold: after an SCL fall, keep the old SDA for field x 50 ns
	// Six bits: seven units of five cycles would not fit in four
	wire [5:0] hold_cyc = 6'(bus_q[6:4] * 6'(dlcr_pkg::HOLD_UNIT_CYC));
	wire       scl_fall = scl_prev_q && !scl_clean;
	always_ff @(posedge clk) begin
		if (reset) begin
			scl_prev_q <= 1'b1;
			hold_cnt_q <= 6'h00;
			sda_hold_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_clean;
			if (scl_fall)
				hold_cnt_q <= hold_cyc;
			else if (hold_cnt_q != 6'h00)
				hold_cnt_q <= hold_cnt_q - 6'h01;
			if (hold_cnt_q == 6'h00 && !(scl_fall && hold_cyc != 6'h00))
				sda_hold_q <= sda_filt;
		end
	end
	assign sda_clean = sda_hold_q;

	// Watchdog: count 2 ms units while a transaction is open
	wire wdog_on = !wdog_q[dlcr_pkg::BIT_WDOG_DIS] && ctl_chan_busy;
	wire unit_tick = unit_q == 32'(WDOG_UNIT - 1);
	always_ff @(posedge clk) begin
		if (reset || !wdog_on) begin
			unit_q  <= 32'h0;
			units_q <= 7'h00;
			abort_q <= 1'b0;
		end else if (!abort_q) begin
			unit_q <= unit_tick ? 32'h0 : unit_q + 32'h1;
			if (unit_tick)
				units_q <= units_q + 7'h01;
			// A zero field times out after the first unit, as if one
			if (unit_tick && units_q + 7'h01 >= wdog_q[7:1])
				abort_q <= 1'b1;
		end
	end
	assign ctl_chan_abort = abort_q;

	AST_CRC_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
		wr_cfg |=> back_crc_enable == $past(reg_wdata[6]))
		else $error("crc enable does not follow write");
	AST_RESERVED: assert property (@(posedge clk) disable iff (reset)
		cfg_q[7] && cfg_q[5] && !cfg_q[1])
		else $error("reserved bits changed");
	AST_FILTER_HOLDS: assert property (@(posedge clk) disable iff (reset)
		filt_en && $changed(horizontal_sync_f) |->
		$past(horizontal_sync) == horizontal_sync_f &&
		$past(horizontal_sync, 2) == horizontal_sync_f)
		else $error("short sync pulse passed");
	AST_NO_FILTER: assert property (@(posedge clk) disable iff (reset)
		!filt_en && $past(!filt_en) |-> vertical_sync_f == $past(vertical_sync))
		else $error("unfiltered sync delayed");
	AST_PASS: assert property (@(posedge clk) disable iff (reset)
		wr_cfg |=> pass_through_enable == $past(reg_wdata[3]))
		else $error("pass-through bit lost");
	AST_ACK: assert property (@(posedge clk) disable iff (reset)
		wr_cfg |=> auto_ack_enable == $past(reg_wdata[2]))
		else $error("ack select lost");
	AST_EDGE: assert property (@(posedge clk) disable iff (reset)
		wr_cfg |=> output_strobe_edge_select == $past(reg_wdata[0]))
		else $error("edge select lost");
	AST_PASS_ALL: assert property (@(posedge clk) disable iff (reset)
		wr_bus |=> pass_all_enable == $past(reg_wdata[7]))
		else $error("pass-all bit lost");
	AST_WDOG_DIS: assert property (@(posedge clk) disable iff (reset)
		wdog_q[0] |=> !ctl_chan_abort)
		else $error("abort while watchdog disabled");
	AST_ABORT_CAUSE: assert property (@(posedge clk) disable iff (reset)
		$rose(ctl_chan_abort) |-> $past(unit_tick) && $past(ctl_chan_busy))
		else $error("abort without timeout");
	AST_HOLD: assert property (@(posedge clk) disable iff (reset)
		hold_cnt_q != 6'h00 |=> $stable(sda_clean))
		else $error("sda changed inside hold");
	AST_HOLD_LOAD: assert property (@(posedge clk) disable iff (reset)
		scl_fall |=> hold_cnt_q == $past(hold_cyc))
		else $error("hold count not loaded");

	COV_ABORT: cover property (@(posedge clk) $rose(ctl_chan_abort));
	COV_FILT: cover property (@(posedge clk) filt_en && $changed(video_data_enable_f));
	COV_HOLD: cover property (@(posedge clk) hold_cnt_q != 6'h00);
endmodule : dlcr_regs
`default_nettype wire

// File: dlcr_host.sv
// Host model on the byte register port of the config registers.
// Assumes it owns addr, wr and wdata; strobes change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module dlcr_host (
	// Clock and read data
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	// Request
	output logic      [7:0] addr,
	output logic            wr,
	output logic      [7:0] wdata
);
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		wdata = 8'h00;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		// A zero timeout is never sent
		if (a == 8'h04 && d[7:1] == 7'h00)
			d[7:1] = 7'h01;
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// Read is combinational, so settle a moment before sampling
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		#1 d = rdata;
	endtask
endmodule // dlcr_host
`default_nettype wire

// File: tb_top.sv
// Testbench for the link config registers.
// Assumes the watchdog unit shortened to 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic       clk = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] addr, wdata, rdata, v;
	logic       wr, sy = 1'b0, scl = 1'b0, busy = 1'b0, sda = 1'b1;
	logic       den_f, hsync_f, vsync_f, scl_c, sda_c, abort;
	logic       crc, pt, ack, pall, edg;
	int         n_fail = 0;
	int         n_checks = 0;
	always #5 clk = ~clk;
	dlcr_host dlcr_host_i (.clk(clk), .rdata(rdata), .addr(addr), .wr(wr),
		.wdata(wdata));
	dlcr_regs #(.WDOG_UNIT(10)) dlcr_regs_i (.clk(clk), .reset(reset),
		.reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rdata(rdata),
		.video_data_enable(sy), .horizontal_sync(sy), .vertical_sync(sy),
		.video_data_enable_f(den_f), .horizontal_sync_f(hsync_f),
		.vertical_sync_f(vsync_f), .scl_in(scl), .sda_in(sda),
		.scl_clean(scl_c), .sda_clean(sda_c), .ctl_chan_busy(busy),
		.ctl_chan_abort(abort),
		.back_crc_enable(crc), .pass_through_enable(pt),
		.auto_ack_enable(ack), .pass_all_enable(pall),
		.output_strobe_edge_select(edg));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_reset;
		dlcr_host_i.rd_reg(8'h03, v);
		chk(v, 8'hf0);
		dlcr_host_i.rd_reg(8'h04, v);
		chk(v, 8'hfe);
		dlcr_host_i.rd_reg(8'h05, v);
		chk(v, 8'h2e);
		dlcr_host_i.rd_reg(8'h00, v);
		chk(v, 8'h00);
	endtask
	task automatic t_cfg;
		dlcr_host_i.wr_reg(8'h03, 8'hff);
		dlcr_host_i.rd_reg(8'h03, v);
		chk(v, 8'hfd);
		chk({4'h0, crc, pt, ack, edg}, 8'h0f);
		dlcr_host_i.wr_reg(8'h03, 8'h00);
		dlcr_host_i.rd_reg(8'h03, v);
		chk(v, 8'ha0);
		chk({4'h0, crc, pt, ack, edg}, 8'h00);
	endtask
	// Drives all three syncs together; seen means all three passed
	task automatic pulse(input int w, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < w + 4; i++) begin
			@(negedge clk);
			sy = (i < w);
			seen = seen | (den_f & hsync_f & vsync_f);
		end
	endtask
	task automatic t_filt;
		logic s;
		dlcr_host_i.wr_reg(8'h03, 8'h10);
		pulse(1, s);
		chk({7'h0, s}, 8'h00);
		pulse(3, s);
		chk({7'h0, s}, 8'h01);
		dlcr_host_i.wr_reg(8'h03, 8'h00);
		pulse(1, s);
		chk({7'h0, s}, 8'h01);
	endtask
	task automatic t_wdog;
		int n;
		for (int f = 1; f < 3; f++) begin
			dlcr_host_i.wr_reg(8'h04, 8'(f << 1));
			busy = 1'b1;
			n = 0;
			while (abort !== 1'b1 && n < 40) begin
				@(negedge clk);
				n++;
			end
			chk({7'h0, n >= 10 * f - 1 && n <= 10 * f + 2}, 8'h01);
			if (n == 40)
				close_out();
			busy = 1'b0;
			repeat (2) @(negedge clk);
		end
		busy = 1'b1;
		dlcr_host_i.wr_reg(8'h04, 8'h03);
		repeat (25) @(negedge clk);
		chk({7'h0, abort}, 8'h00);
		busy = 1'b0;
	endtask
	task automatic t_bus;
		dlcr_host_i.wr_reg(8'h05, 8'h80);
		dlcr_host_i.rd_reg(8'h05, v);
		chk(v, 8'h80);
		chk({7'h0, pall}, 8'h01);
		scl = 1'b1;
		@(negedge clk);
		chk({7'h0, scl_c}, 8'h01);
		dlcr_host_i.wr_reg(8'h05, 8'h04);
		chk({7'h0, pall}, 8'h00);
		scl = 1'b0;
		@(negedge clk);
		scl = 1'b1;
		repeat (4) begin
			@(negedge clk);
			chk({7'h0, scl_c}, 8'h01);
		end
		// One hold unit, no glitch filter: old SDA stays for 5 cycles
		dlcr_host_i.wr_reg(8'h05, 8'h10);
		repeat (2) @(negedge clk);
		scl = 1'b0;
		sda = 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h0, sda_c}, 8'h01);
		repeat (5) @(negedge clk);
		chk({7'h0, sda_c}, 8'h00);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		reset = 1'b0;
		t_reset();
		t_cfg();
		t_filt();
		t_wdog();
		t_bus();
		close_out();
	end
endmodule // tb_top
`default_nettype wire
